// ==== tle_defs.vh ====
`ifndef TLE_DEFS_VH
`define TLE_DEFS_VH

// ----------------------------------------------------------------
// Register indices on the internal register port
// ----------------------------------------------------------------
`define TLE_IDX_UPPER 3'h2
`define TLE_IDX_LOWER 3'h3
`define TLE_IDX_CRIT 3'h4
`define TLE_IDX_TEMP 3'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TLE_SIGN_BIT 12
`define TLE_LIM_MSB 12
`define TLE_LIM_LSB 2
`define TLE_TMP_MSB 12
`define TLE_FLAG_CRIT 15
`define TLE_FLAG_HIGH 14
`define TLE_FLAG_LOW 13

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TLE_LIMIT_RST 11'h000
`define TLE_TEMP_RST 13'h0000

// ----------------------------------------------------------------
// Hysteresis selections and offsets in 0.0625 degree steps
// ----------------------------------------------------------------
`define TLE_HYS_OFF 2'h0
`define TLE_HYS_1P5 2'h1
`define TLE_HYS_3P0 2'h2
`define TLE_HYS_6P0 2'h3
`define TLE_HYS_1P5_CNT 14'h0018
`define TLE_HYS_3P0_CNT 14'h0030
`define TLE_HYS_6P0_CNT 14'h0060

// ----------------------------------------------------------------
// Resolution capability field codes
// ----------------------------------------------------------------
`define TLE_RES_9BIT 2'h0
`define TLE_RES_10BIT 2'h1
`define TLE_RES_11BIT 2'h2
`define TLE_RES_12BIT 2'h3

`endif

// ==== tle_event_logic.v ====
// What this block does
// - Limits: bits15:13 zero, sign 12, 11:2 value
// - Limit bits 1 and 0 always zero
// - Temperature bits 12:0 two's complement, 0.0625 LSB
// - All values two's complement, sign bit 12
// - Bits below advertised resolution read zero
// - Bit 15 set at or above critical
// - Bit 14 set strictly above upper limit
// - Bit 13 set strictly below lower limit
// - Interrupt mode latches crossings, clear bit releases
// - Above critical, interrupt event holds, clear ignored
// - Comparator mode asserts outside window, no clear
// - Critical-only mode asserts only at or above critical, and holds until the critical release point
// - Trip points are the limits; release points are offset by selected hysteresis
// - Shutdown freezes temperature and alarm states
// - Evaluate on each sample, refresh at rate
// - Limit writes re-evaluate event immediately, except during shutdown
// - Hysteresis codes: 0, 1.5, 3, 6 degrees
// - Polarity bit: zero active low, one high
// - Mode bit: zero comparator, one interrupt
// - Critical-only select limits events to critical
`timescale 1ns/1ps
`default_nettype none
`include "tle_defs.vh"

module tle_event_logic #(
    parameter TEMP_W = 13,
    parameter LIM_W = 11
) (
    input wire CORE_CLK,
    input wire RESET_N,
    input wire [2:0] REG_ADDR,
    input wire REG_WR,
    input wire [15:0] REG_WDATA,
    output reg [15:0] REG_RDATA,
    input wire SAMPLE_STB,
    input wire [12:0] SAMPLE_DATA,
    input wire [1:0] RESOLUTION_CAPABILITY_FIELD,
    input wire [1:0] HYSTERESIS_SELECT,
    input wire EVENT_MODE_INT,
    input wire ALERT_POLARITY_SELECT,
    input wire CRITICAL_ONLY_SELECT,
    input wire EVENT_ENABLE,
    input wire SENSOR_SHUTDOWN_BIT,
    input wire CLEAR_EVENT,
    output reg EVENT_OUT,
    output reg EVENT_OE_N,
    output reg ALERT_STATUS_COPY
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Limits carry 0.25 degree steps; shifting by two puts them on the
    // same 0.0625 degree grid as samples, one bit of headroom for offsets
    function [13:0] lim_to_16th;
        input [10:0] lim;
        begin
            lim_to_16th = {lim[10], lim, 2'b00};
        end
    endfunction

    function [13:0] hys_offset;
        input [1:0] sel;
        begin
            case (sel)
                `TLE_HYS_1P5: hys_offset = `TLE_HYS_1P5_CNT;
                `TLE_HYS_3P0: hys_offset = `TLE_HYS_3P0_CNT;
                `TLE_HYS_6P0: hys_offset = `TLE_HYS_6P0_CNT;
                default: hys_offset = 14'h0000;
            endcase
        end
    endfunction

    function [12:0] res_mask;
        input [1:0] res;
        begin
            case (res)
                `TLE_RES_9BIT: res_mask = 13'h1ff8;
                `TLE_RES_10BIT: res_mask = 13'h1ffc;
                `TLE_RES_11BIT: res_mask = 13'h1ffe;
                default: res_mask = 13'h1fff;
            endcase
        end
    endfunction

    // Write index decode; any other index leaves the limits untouched
    function is_limit_idx;
        input [2:0] idx;
        begin
            case (idx)
                `TLE_IDX_UPPER: is_limit_idx = 1'b1;
                `TLE_IDX_LOWER: is_limit_idx = 1'b1;
                `TLE_IDX_CRIT: is_limit_idx = 1'b1;
                default: is_limit_idx = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    reg [LIM_W-1:0] upper_r;
    reg [LIM_W-1:0] lower_r;
    reg [LIM_W-1:0] crit_r;
    reg [TEMP_W-1:0] temp_r;
    reg eval_r;
    reg hi_st_r;
    reg lo_st_r;
    reg cr_st_r;
    reg latch_r;
    reg [15:0] rdata_nxt;

    wire lim_wr;
    wire lim_eval;
    wire sample_take;
    wire signed [13:0] t_s;
    wire signed [13:0] up_s;
    wire signed [13:0] lo_s;
    wire signed [13:0] cr_s;
    wire signed [13:0] hys_s;
    wire signed [13:0] up_rel_s;
    wire signed [13:0] lo_rel_s;
    wire signed [13:0] cr_rel_s;
    wire flag_crit;
    wire flag_high;
    wire flag_low;
    wire hi_nxt;
    wire lo_nxt;
    wire cr_nxt;
    wire alarm_change;
    wire latch_nxt;
    wire evt_level;
    wire asserted;
    wire pin_low;

    // ------------------------------------------------------------
    // Limit registers
    // ------------------------------------------------------------
    assign lim_wr = REG_WR && is_limit_idx(REG_ADDR);

    // Limit writes during shutdown are stored but not judged, so the held
    // event level stays as it was until conversions resume
    assign lim_eval = lim_wr && !SENSOR_SHUTDOWN_BIT;

    always @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            upper_r <= `TLE_LIMIT_RST;
            lower_r <= `TLE_LIMIT_RST;
            crit_r <= `TLE_LIMIT_RST;
        end else if (REG_WR) begin
            // Only sign and 0.25 degree bits are kept; the rest is dropped
            case (REG_ADDR)
                `TLE_IDX_UPPER: upper_r <= REG_WDATA[`TLE_LIM_MSB:`TLE_LIM_LSB];
                `TLE_IDX_LOWER: lower_r <= REG_WDATA[`TLE_LIM_MSB:`TLE_LIM_LSB];
                `TLE_IDX_CRIT: crit_r <= REG_WDATA[`TLE_LIM_MSB:`TLE_LIM_LSB];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sample capture
    // ------------------------------------------------------------

    // No conversion is recorded while shut down, so the last value holds
    assign sample_take = SAMPLE_STB && !SENSOR_SHUTDOWN_BIT;

    always @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            temp_r <= `TLE_TEMP_RST;
        end else if (sample_take) begin
            temp_r <= SAMPLE_DATA;
        end
    end

    // One cycle after a sample or limit write the new values are settled
    always @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            eval_r <= 1'b0;
        end else begin
            eval_r <= sample_take || lim_eval;
        end
    end

    // ------------------------------------------------------------
    // Comparisons
    // ------------------------------------------------------------
    assign t_s = {temp_r[`TLE_SIGN_BIT], temp_r};
    assign up_s = lim_to_16th(upper_r);
    assign lo_s = lim_to_16th(lower_r);
    assign cr_s = lim_to_16th(crit_r);
    assign hys_s = hys_offset(HYSTERESIS_SELECT);

    // Plain status flags for the temperature register, no hysteresis
    assign flag_crit = (t_s >= cr_s);
    assign flag_high = (t_s > up_s);
    assign flag_low = (t_s < lo_s);

    // ------------------------------------------------------------
    // Release points
    // ------------------------------------------------------------

    // Hysteresis only moves the release point, so small noise around a
    // limit cannot make the event chatter; 14 bits leave room for the
    // largest offset past either end of the limit range
    assign up_rel_s = up_s - hys_s;
    assign lo_rel_s = lo_s + hys_s;
    assign cr_rel_s = cr_s - hys_s;

    assign hi_nxt = hi_st_r ? (t_s > up_rel_s) : (t_s > up_s);
    assign lo_nxt = lo_st_r ? (t_s < lo_rel_s) : (t_s < lo_s);
    assign cr_nxt = cr_st_r ? (t_s >= cr_rel_s) : (t_s >= cr_s);

    always @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            hi_st_r <= 1'b0;
            lo_st_r <= 1'b0;
            cr_st_r <= 1'b0;
        end else if (eval_r) begin
            hi_st_r <= hi_nxt;
            lo_st_r <= lo_nxt;
            cr_st_r <= cr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Event decision
    // ------------------------------------------------------------
    assign alarm_change = eval_r && !CRITICAL_ONLY_SELECT &&
        ((hi_nxt != hi_st_r) || (lo_nxt != lo_st_r));

    // A new crossing in the same cycle as a clear keeps the latch set;
    // above critical the clear is refused
    assign latch_nxt = alarm_change ? 1'b1 :
        ((CLEAR_EVENT && !cr_st_r) ? 1'b0 : latch_r);

    always @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            latch_r <= 1'b0;
        end else if (EVENT_MODE_INT) begin
            latch_r <= latch_nxt;
        end else begin
            latch_r <= 1'b0;
        end
    end

    assign evt_level = CRITICAL_ONLY_SELECT ? cr_st_r :
        (EVENT_MODE_INT ? (latch_r || cr_st_r) :
        (hi_st_r || lo_st_r || cr_st_r));
    assign asserted = evt_level && EVENT_ENABLE;

    // A disabled output sits at its inactive level: released when active
    // low, pulled to ground when active high
    assign pin_low = ALERT_POLARITY_SELECT ? !asserted : asserted;

    // Alarm states hold during shutdown; a clear, enable, polarity or mode change still acts here
    always @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            EVENT_OUT <= 1'b0;
            EVENT_OE_N <= 1'b1;
            ALERT_STATUS_COPY <= 1'b0;
        end else begin
            EVENT_OUT <= 1'b0;
            EVENT_OE_N <= !pin_low;
            ALERT_STATUS_COPY <= asserted;
        end
    end

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always @* begin
        rdata_nxt = 16'h0000;
        case (REG_ADDR)
            `TLE_IDX_UPPER: rdata_nxt = {3'h0, upper_r, 2'h0};
            `TLE_IDX_LOWER: rdata_nxt = {3'h0, lower_r, 2'h0};
            `TLE_IDX_CRIT: rdata_nxt = {3'h0, crit_r, 2'h0};
            `TLE_IDX_TEMP: begin
                rdata_nxt[`TLE_FLAG_CRIT] = flag_crit;
                rdata_nxt[`TLE_FLAG_HIGH] = flag_high;
                rdata_nxt[`TLE_FLAG_LOW] = flag_low;
                rdata_nxt[`TLE_TMP_MSB:0] = temp_r & res_mask(RESOLUTION_CAPABILITY_FIELD);
            end
            default: rdata_nxt = 16'h0000;
        endcase
    end

    always @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            REG_RDATA <= 16'h0000;
        end else begin
            REG_RDATA <= rdata_nxt;
        end
    end

endmodule // tle_event_logic
`default_nettype wire

// ==== tle_event_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// --------
// Event logic port checks
// --------
module tle_event_chk (
    input wire CORE_CLK,
    input wire RESET_N,
    input wire [2:0] REG_ADDR,
    input wire REG_WR,
    input wire [15:0] REG_WDATA,
    input wire [15:0] REG_RDATA,
    input wire [1:0] RESOLUTION_CAPABILITY_FIELD,
    input wire [1:0] HYSTERESIS_SELECT,
    input wire EVENT_MODE_INT,
    input wire ALERT_POLARITY_SELECT,
    input wire CRITICAL_ONLY_SELECT,
    input wire EVENT_ENABLE,
    input wire SENSOR_SHUTDOWN_BIT,
    input wire CLEAR_EVENT,
    input wire EVENT_OUT,
    input wire EVENT_OE_N,
    input wire ALERT_STATUS_COPY
);
    wire [5:0] cfg = {HYSTERESIS_SELECT, EVENT_MODE_INT, ALERT_POLARITY_SELECT,
        CRITICAL_ONLY_SELECT, EVENT_ENABLE};
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);
    chk_pin_data_low: assert property (EVENT_OUT == 1'b0)
        else $error("pin data not low");
    // Config must settle first, it may reach the pin late
    chk_pin_polarity: assert property (
        $past(RESET_N, 4) && cfg == $past(cfg, 4)
        |-> EVENT_OE_N == !(ALERT_STATUS_COPY ^ ALERT_POLARITY_SELECT))
        else $error("pin level wrong");
    chk_limit_read: assert property (
        REG_WR && REG_ADDR inside {3'h2, 3'h3, 3'h4} ##1 !REG_WR && $stable(REG_ADDR)
        |=> REG_RDATA == ($past(REG_WDATA, 2) & 16'h1ffc))
        else $error("limit readback wrong");
    chk_unmapped_read: assert property (
        !(REG_ADDR inside {[3'h2:3'h5]}) |=> REG_RDATA == 16'h0000)
        else $error("unmapped read not zero");
    chk_res_mask: assert property (
        REG_ADDR == 3'h5
        |=> (REG_RDATA[2:0] & (3'h7 >> $past(RESOLUTION_CAPABILITY_FIELD))) == 3'h0)
        else $error("low bits not masked");
    chk_halt_event: assert property (
        (SENSOR_SHUTDOWN_BIT && !CLEAR_EVENT && $stable(cfg))[*4]
        |=> $stable(ALERT_STATUS_COPY))
        else $error("event moved in shutdown");
    chk_halt_temp: assert property (
        (SENSOR_SHUTDOWN_BIT && REG_ADDR == 3'h5 && !REG_WR
        && $stable(RESOLUTION_CAPABILITY_FIELD))[*4] |=> $stable(REG_RDATA))
        else $error("temperature moved in shutdown");
    chk_off_idle: assert property ((!EVENT_ENABLE)[*4] |-> !ALERT_STATUS_COPY)
        else $error("disabled event active");
    cover property (REG_WR && REG_ADDR == 3'h4);
    cover property (SENSOR_SHUTDOWN_BIT && ALERT_STATUS_COPY);
    cover property (EVENT_MODE_INT && CLEAR_EVENT && ALERT_STATUS_COPY);
endmodule // tle_event_chk
`default_nettype wire

// ==== tle_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// --------
// Host side of the register port
// --------
module tle_host_model (
    input wire CORE_CLK,
    output logic [2:0] REG_ADDR,
    output logic REG_WR,
    output logic [15:0] REG_WDATA,
    input wire [15:0] REG_RDATA
);
    initial REG_ADDR = 3'h0;
    initial REG_WR = 1'b0;
    initial REG_WDATA = 16'h0000;
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge CORE_CLK) #5 REG_ADDR = a;
        REG_WR = 1'b1;
        REG_WDATA = d;
        // Data flips after the strobe so a late capture shows
        @(posedge CORE_CLK) #5 REG_WR = 1'b0;
        REG_WDATA = ~d;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge CORE_CLK) #5 REG_ADDR = a;
        @(posedge CORE_CLK) #5 d = REG_RDATA;
    endtask
endmodule // tle_host_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// --------
// Event logic bench
// --------
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, stb = 1'b0, mode = 1'b0, pol = 1'b0;
    logic conly = 1'b0, en = 1'b0, sensor_shutdown_bit = 1'b0, clr = 1'b0;
    logic [12:0] sdata = 13'h0000;
    logic [1:0] res = 2'h3, hys = 2'h0;
    logic [15:0] rv, ev;
    wire [15:0] wdata, rdata;
    wire [2:0] addr;
    wire wr, eout, oe_n, copy;
    int err_total = 0, comparisons = 0, cyc = 0, t = 0, p, i, rnd;
    int lim [2:4] = '{0, 0, 0};
    int sq [6] = '{401, 400, -401, -400, 800, 799};
    bit hi, lo, cr, latch, act, phi, plo;
    always #50 clk = ~clk;
    tle_host_model host_u (.CORE_CLK(clk), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata),
        .REG_RDATA(rdata));
    tle_event_logic dut_u (.CORE_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WR(wr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .SAMPLE_STB(stb), .SAMPLE_DATA(sdata),
        .RESOLUTION_CAPABILITY_FIELD(res), .HYSTERESIS_SELECT(hys), .EVENT_MODE_INT(mode),
        .ALERT_POLARITY_SELECT(pol), .CRITICAL_ONLY_SELECT(conly), .EVENT_ENABLE(en),
        .SENSOR_SHUTDOWN_BIT(sensor_shutdown_bit), .CLEAR_EVENT(clr), .EVENT_OUT(eout), .EVENT_OE_N(oe_n),
        .ALERT_STATUS_COPY(copy));
    task automatic give_verdict();
        if (err_total == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_pin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t pin %b expected %b", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    function automatic int sx(input logic [12:0] v);
        return v[12] ? int'(v) - 8192 : int'(v);
    endfunction
    // Release points move by the hysteresis, set points do not
    task automatic eval();
        int h;
        h = (hys == 2'h0) ? 0 : (12 << hys);
        phi = hi;
        plo = lo;
        hi = (t > lim[2]) ? 1'b1 : (t <= lim[2] - h) ? 1'b0 : hi;
        lo = (t < lim[3]) ? 1'b1 : (t >= lim[3] + h) ? 1'b0 : lo;
        cr = (t >= lim[4]) ? 1'b1 : (t < lim[4] - h) ? 1'b0 : cr;
        if (!mode) latch = 1'b0;
        else if (!conly && (hi != phi || lo != plo)) latch = 1'b1;
        act = conly ? cr : mode ? (latch | cr) : (hi | lo | cr);
    endtask
    task automatic wr_lim(input logic [2:0] a, input logic [15:0] d);
        host_u.wr(a, d);
        if (a >= 3'h2 && a <= 3'h4) lim[a] = sx(d[12:0] & 13'h1ffc);
        eval();
    endtask
    task automatic check();
        tick(4);
        cmp_pin(copy, en & act);
        cmp_pin(oe_n, !((en & act) ^ pol));
        cmp_pin(eout, 1'b0);
        host_u.rd(3'h5, rv);
        ev = {t >= lim[4], t > lim[2], t < lim[3], t[12:0] & (13'h1fff << (2'h3 - res))};
        cmp_word(rv, ev);
        if (mode) begin
            tick(1);
            clr = 1'b1;
            tick(1);
            clr = 1'b0;
            if (!cr) latch = 1'b0;
            act = conly ? cr : (latch | cr);
            tick(2);
            cmp_pin(copy, en & act);
        end
    endtask
    task automatic send(input int v);
        tick(1);
        stb = 1'b1;
        sdata = v[12:0];
        tick(1);
        stb = 1'b0;
        sdata = ~sdata;
    endtask
    task automatic step(input int v);
        rnd = $urandom;
        pol = rnd[0];
        en = rnd[2:1] != 2'h0;
        res = rnd[4:3];
        send(v);
        t = v;
        eval();
        check();
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        rnd = $urandom(1849);
        tick(12);
        cmp_pin(oe_n, 1'b1);
        cmp_word(rdata, 16'h0000);
        rst_n = 1'b1;
        for (i = 2; i < 5; i++) begin
            rnd = $urandom;
            wr_lim(i[2:0], rnd[15:0]);
            host_u.rd(i[2:0], rv);
            cmp_word(rv, rnd[15:0] & 16'h1ffc);
        end
        wr_lim(3'h5, 16'hffff);
        host_u.rd(3'h7, rv);
        cmp_word(rv, 16'h0000);
        wr_lim(3'h2, 16'h0190);
        wr_lim(3'h3, 16'h1e70);
        wr_lim(3'h4, 16'h0320);
        for (p = 0; p < 12; p++) begin
            hys = p[1:0];
            mode = p / 4 == 1;
            conly = p / 4 == 2 || p == 7;
            for (i = 0; i < 7; i++) step(i < 6 ? sq[i] : 160 + int'($urandom % 64));
            wr_lim(3'h2, 16'h0080);
            check();
            wr_lim(3'h2, 16'h0190);
            check();
        end
        step(808);
        sensor_shutdown_bit = 1'b1;
        send(0);
        check();
        // Host lifts the held level off the shared line while still shut down
        en = 1'b0;
        pol = ~pol;
        tick(3);
        cmp_pin(copy, 1'b0);
        cmp_pin(oe_n, !pol);
        sensor_shutdown_bit = 1'b0;
        give_verdict();
    end
endmodule // tb_top
bind tle_event_logic tle_event_chk chk_u (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .RESOLUTION_CAPABILITY_FIELD(RESOLUTION_CAPABILITY_FIELD),
    .HYSTERESIS_SELECT(HYSTERESIS_SELECT), .EVENT_MODE_INT(EVENT_MODE_INT),
    .ALERT_POLARITY_SELECT(ALERT_POLARITY_SELECT), .CRITICAL_ONLY_SELECT(CRITICAL_ONLY_SELECT),
    .EVENT_ENABLE(EVENT_ENABLE), .SENSOR_SHUTDOWN_BIT(SENSOR_SHUTDOWN_BIT),
    .CLEAR_EVENT(CLEAR_EVENT), .EVENT_OUT(EVENT_OUT), .EVENT_OE_N(EVENT_OE_N),
    .ALERT_STATUS_COPY(ALERT_STATUS_COPY));
`default_nettype wire
